//--- core/tefsw_pkg.sv
// Package with register map, field positions and carrier types of the timer event flags.
package tefsw_pkg;

  localparam int NCH   = 4;
  localparam int CNT_W = 16;

  //////////////////////////////////////////////////////////////////////////////
  // Register byte offsets within the block.
  localparam logic [11:0] TEFSW_CTRL_OFS  = 12'h000;
  localparam logic [11:0] TEFSW_INTEN_OFS = 12'h00c;
  localparam logic [11:0] TEFSW_FLAGS_OFS = 12'h010;
  localparam logic [11:0] TEFSW_SWEV_OFS  = 12'h014;
  localparam logic [11:0] TEFSW_CHOUT_OFS = 12'h020;
  localparam logic [11:0] TEFSW_CAPV_OFS  = 12'h034;
  localparam logic [11:0] TEFSW_CAPV_STEP = 12'h004;

  //////////////////////////////////////////////////////////////////////////////
  // Bit positions of the flag and enable registers; all but the over-capture bits are shared by the soft event register.
  localparam int UPD_BIT  = 0;
  localparam int CH_BIT0  = 1;
  localparam int COMM_BIT = 5;
  localparam int TRIG_BIT = 6;
  localparam int BRK_BIT  = 7;
  localparam int OVC_BIT0 = 9;
  localparam int SWEV_W   = 8;

  // Control register fields.
  localparam int CTRL_DOWN_BIT   = 0;
  localparam int CTRL_CENTER_BIT = 1;
  localparam int CTRL_PAUSE_BIT  = 2;
  localparam int CTRL_TRGFAL_BIT = 3;
  localparam int CTRL_CSE_BIT    = 4;
  localparam int CTRL_POE_BIT    = 5;
  localparam int CTRL_CHIN_LSB   = 8;

  // Channel output control field width per channel.
  localparam int CHOUT_W = 5;

  //////////////////////////////////////////////////////////////////////////////
  // Reset values and writable masks.
  localparam logic [31:0] FLAGS_RST  = 32'h0000_0000;
  localparam logic [31:0] FLAGS_MASK = 32'h0000_1eff;
  localparam logic [31:0] INTEN_RST  = 32'h0000_0000;
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK  = 32'h0000_0f3f;
  localparam logic [7:0]  SWEV_RST   = 8'h00;
  localparam logic [CNT_W-1:0] CAPV_RST = 16'h0000;

  //////////////////////////////////////////////////////////////////////////////
  // Carrier types.
  typedef struct packed {
    logic       en;
    logic       nen;
    logic [2:0] comctl;
  } tefsw_chout_t;

  localparam tefsw_chout_t CHOUT_RST = 5'h00;

  typedef struct packed {
    logic           trig_level;
    logic           update;
    logic           commutation;
    logic           break_det;
    logic [NCH-1:0] capture;
    logic [NCH-1:0] compare;
  } tefsw_hw_evt_t;

  typedef struct packed {
    logic cnt_clear;
    logic cnt_reload;
    logic psc_clear;
  } tefsw_cnt_ctl_t;

endpackage

//--- core/tefsw_top.sv
// Timer event flags, software event generation and AHB-Lite register slave.
//
// Behaviour
// RQ1: Trigger event sets sticky trigger flag bit 6.
// RQ2: Pause mode: both trigger edges; else active edge.
// RQ3: Commutation event sets sticky flag bit 5.
// RQ4: Channel 0 flag: capture in input, compare otherwise.
// RQ5: Channels 1-3 flags at bits 2-4.
// RQ6: Reading channel capture value clears input-mode flag.
// RQ7: Update event sets sticky update flag bit 0.
// RQ8: Soft event bits self-clear after producing event.
// RQ9: Break force clears output enable, sets break flag.
// RQ10: Trigger force sets trigger flag, may interrupt.
// RQ11: Commutation force loads output controls per shadow enable.
// RQ12: Channel 0 force sets its flag, may interrupt.
// RQ13: Forced input capture stores counter, flags over-capture.
// RQ14: Channel 1-3 force bits at bits 2-4.
// RQ15: Update force clears counter, or reloads when down.
// RQ16: Update force also clears prescaler same cycle.
// RQ17: Capture with flag still set sets over-capture flag.
// RQ18: Writing zero forces nothing; soft register reads zero.
//
// Register access over AHB-Lite is this design's own decision.
module tefsw_top
  import tefsw_pkg::*;
(
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic                           hreadyout,
  output logic                           hresp,
  output logic [31:0]                    hrdata,
  input  wire tefsw_pkg::tefsw_hw_evt_t  hw_evt,
  input  wire logic [tefsw_pkg::CNT_W-1:0] cnt_value,
  output tefsw_pkg::tefsw_cnt_ctl_t      cnt_ctl,
  output logic                           primary_output_enable,
  output tefsw_pkg::tefsw_chout_t [tefsw_pkg::NCH-1:0] chan_out_active,
  output logic                           irq
);
  import tefsw_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Bus slave state.
  logic                              acc;
  logic                              rd_take;
  logic                              wr_pend_reg;
  logic [11:0]                       waddr_reg;
  logic [31:0]                       hrdata_reg;
  logic [31:0]                       rdata_next;
  logic                              wr_ctrl;
  logic                              wr_inten;
  logic                              wr_flags;
  logic                              wr_swev;
  logic                              wr_chout;

  // Block registers.
  logic [31:0]                       ctrl_reg;
  logic [31:0]                       inten_reg;
  logic [31:0]                       flags_reg;
  logic [31:0]                       flags_next;
  logic [31:0]                       flags_set;
  logic [31:0]                       flags_clr;
  logic [SWEV_W-1:0]                 swev_reg;
  logic                              trig_prev_reg;
  tefsw_chout_t [NCH-1:0]            chout_shadow_reg;
  tefsw_chout_t [NCH-1:0]            chout_active_reg;
  logic [NCH-1:0][CNT_W-1:0]         capv_reg;

  // Event terms.
  logic                              trig_rise;
  logic                              trig_fall;
  logic                              trig_evt;
  logic                              comm_evt;
  logic [NCH-1:0]                    chan_in;
  logic [NCH-1:0]                    cap_evt;
  logic [NCH-1:0]                    cmp_evt;
  logic [NCH-1:0]                    ch_set;
  logic [NCH-1:0]                    ovc_set;
  logic [NCH-1:0]                    capv_rd;

  //////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave. Reads are answered with zero wait states from the
  // address phase; a read that directly follows a write gets one wait
  // state, so that it never returns the value from before the write.
  assign acc       = hsel & htrans[1] & hready;
  assign rd_take   = acc & ~hwrite;
  assign hreadyout = ~(wr_pend_reg & hsel & htrans[1] & ~hwrite);
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      waddr_reg   <= 12'h000;
    end else begin
      wr_pend_reg <= acc & hwrite;
      if (acc) begin
        waddr_reg <= haddr[11:0];
      end
    end
  end

  assign wr_ctrl  = wr_pend_reg & (waddr_reg == TEFSW_CTRL_OFS);
  assign wr_inten = wr_pend_reg & (waddr_reg == TEFSW_INTEN_OFS);
  assign wr_flags = wr_pend_reg & (waddr_reg == TEFSW_FLAGS_OFS);
  assign wr_swev  = wr_pend_reg & (waddr_reg == TEFSW_SWEV_OFS);
  assign wr_chout = wr_pend_reg & (waddr_reg == TEFSW_CHOUT_OFS);

  // Read mux; unmapped addresses read as zero with an OKAY answer.
  always_comb begin
    rdata_next = 32'h0000_0000;
    case (haddr[11:0])
      TEFSW_CTRL_OFS:  rdata_next = ctrl_reg;
      TEFSW_INTEN_OFS: rdata_next = inten_reg;
      TEFSW_FLAGS_OFS: rdata_next = flags_reg;
      TEFSW_SWEV_OFS:  rdata_next = 32'h0000_0000; // RQ18
      TEFSW_CHOUT_OFS: rdata_next = {12'h000, chout_shadow_reg};
      default: begin
        for (int i = 0; i < NCH; i++) begin
          if (haddr[11:0] == TEFSW_CAPV_OFS + 12'(i) * TEFSW_CAPV_STEP) begin
            rdata_next = {{(32 - CNT_W){1'b0}}, capv_reg[i]};
          end
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (rd_take) begin
      hrdata_reg <= rdata_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control and interrupt enable registers.
  assign primary_output_enable = ctrl_reg[CTRL_POE_BIT];
  assign chan_in = ctrl_reg[CTRL_CHIN_LSB +: NCH];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= hwdata & CTRL_MASK;
      end
      // A forced break wins over a software write of the enable.
      if (swev_reg[BRK_BIT]) begin
        ctrl_reg[CTRL_POE_BIT] <= 1'b0; // RQ9
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      inten_reg <= INTEN_RST;
    end else if (wr_inten) begin
      inten_reg <= hwdata & FLAGS_MASK;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Soft event register: a written one lives for exactly one cycle, in
  // which its event is produced, then hardware clears it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      swev_reg <= SWEV_RST;
    end else if (wr_swev) begin
      swev_reg <= hwdata[SWEV_W-1:0]; // RQ8 RQ18
    end else begin
      swev_reg <= SWEV_RST; // RQ8
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Trigger edge detection. The input is synchronous to hclk.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_prev_reg <= 1'b0;
    end else begin
      trig_prev_reg <= hw_evt.trig_level;
    end
  end

  assign trig_rise = hw_evt.trig_level & ~trig_prev_reg;
  assign trig_fall = ~hw_evt.trig_level & trig_prev_reg;

  always_comb begin
    if (ctrl_reg[CTRL_PAUSE_BIT]) begin
      trig_evt = trig_rise | trig_fall; // RQ2
    end else if (ctrl_reg[CTRL_TRGFAL_BIT]) begin
      trig_evt = trig_fall; // RQ2
    end else begin
      trig_evt = trig_rise; // RQ2
    end
  end

  assign comm_evt = hw_evt.commutation | swev_reg[COMM_BIT];

  //////////////////////////////////////////////////////////////////////////////
  // Per-channel capture, compare, over-capture and capture value logic.
  for (genvar i = 0; i < NCH; i++) begin : g_chan
    assign cap_evt[i] = chan_in[i] &
                        (hw_evt.capture[i] | swev_reg[CH_BIT0 + i]); // RQ13
    assign cmp_evt[i] = ~chan_in[i] & hw_evt.compare[i]; // RQ4 RQ5
    assign ch_set[i]  = cap_evt[i] | cmp_evt[i] |
                        swev_reg[CH_BIT0 + i]; // RQ12 RQ14
    assign ovc_set[i] = cap_evt[i] & flags_reg[CH_BIT0 + i]; // RQ17 RQ13
    assign capv_rd[i] = rd_take & chan_in[i] &
                        (haddr[11:0] == TEFSW_CAPV_OFS +
                         12'(i) * TEFSW_CAPV_STEP); // RQ6

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        capv_reg[i] <= CAPV_RST;
      end else if (cap_evt[i]) begin
        capv_reg[i] <= cnt_value; // RQ13
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Flag register. Software clears by writing ones; any set in the same
  // cycle wins over a clear so that no event is lost.
  always_comb begin
    flags_set = 32'h0000_0000;
    flags_set[UPD_BIT]  = hw_evt.update | swev_reg[UPD_BIT]; // RQ7
    flags_set[COMM_BIT] = comm_evt; // RQ3
    flags_set[TRIG_BIT] = trig_evt | swev_reg[TRIG_BIT]; // RQ1 RQ10
    flags_set[BRK_BIT]  = hw_evt.break_det | swev_reg[BRK_BIT]; // RQ9
    flags_set[CH_BIT0 +: NCH]  = ch_set; // RQ4 RQ5
    flags_set[OVC_BIT0 +: NCH] = ovc_set; // RQ17
    flags_clr = wr_flags ? (hwdata & FLAGS_MASK) : 32'h0000_0000;
    flags_clr[CH_BIT0 +: NCH] = flags_clr[CH_BIT0 +: NCH] | capv_rd; // RQ6
    flags_next = ((flags_reg & ~flags_clr) | flags_set) & FLAGS_MASK;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_reg <= FLAGS_RST;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // Level interrupt while any enabled flag is set.
  assign irq = |(flags_reg & inten_reg); // RQ9 RQ10 RQ12

  //////////////////////////////////////////////////////////////////////////////
  // Channel output controls. With shadowing on, software writes only reach
  // the outputs at a commutation event, so a new pattern switches on all
  // channels at once; with it off, the outputs follow the shadow register one cycle later.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chout_shadow_reg <= {NCH{CHOUT_RST}};
    end else if (wr_chout) begin
      chout_shadow_reg <= hwdata[NCH*CHOUT_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chout_active_reg <= {NCH{CHOUT_RST}};
    end else if (!ctrl_reg[CTRL_CSE_BIT] || comm_evt) begin
      chout_active_reg <= chout_shadow_reg; // RQ11
    end
  end

  assign chan_out_active = chout_active_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Counter and prescaler commands from a forced update.
  always_comb begin
    cnt_ctl.cnt_clear  = swev_reg[UPD_BIT] &
                         (ctrl_reg[CTRL_CENTER_BIT] |
                          ~ctrl_reg[CTRL_DOWN_BIT]); // RQ15
    cnt_ctl.cnt_reload = swev_reg[UPD_BIT] &
                         ~ctrl_reg[CTRL_CENTER_BIT] &
                         ctrl_reg[CTRL_DOWN_BIT]; // RQ15
    cnt_ctl.psc_clear  = swev_reg[UPD_BIT]; // RQ16
  end

  // Transfer size is not checked: only whole-word accesses are supported.
  logic unused_ok;
  assign unused_ok = &{1'b0, hsize, haddr[31:12]};

endmodule

//--- verification/tefsw_assertions.sv
// Checker of flag, interrupt and soft event timing at the block's ports.
module tefsw_assertions (
  input wire logic                         hclk,
  input wire logic                         hresetn,
  input wire logic                         hsel,
  input wire logic [31:0]                  haddr,
  input wire logic [1:0]                   htrans,
  input wire logic                         hwrite,
  input wire logic [2:0]                   hsize,
  input wire logic [31:0]                  hwdata,
  input wire logic                         hready,
  input wire logic                         hreadyout,
  input wire logic                         hresp,
  input wire logic [31:0]                  hrdata,
  input wire tefsw_pkg::tefsw_hw_evt_t     hw_evt,
  input wire logic [tefsw_pkg::CNT_W-1:0]  cnt_value,
  input wire tefsw_pkg::tefsw_cnt_ctl_t    cnt_ctl,
  input wire logic                         primary_output_enable,
  input wire tefsw_pkg::tefsw_chout_t [tefsw_pkg::NCH-1:0] chan_out_active,
  input wire logic                         irq
);
  import tefsw_pkg::*;
  logic        ap_q;
  logic        wr_q;
  logic [11:0] ad_q;
  logic [31:0] ctrl_q;
  logic [31:0] inten_q;
  logic [31:0] chout_q;
  logic        dp;
  logic        sw;

  // Shadows follow completed writes, so the setup seen by the block is known.
  assign dp = ap_q && hready;
  assign sw = dp && wr_q && ad_q == TEFSW_SWEV_OFS;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_q <= 1'b0;
      wr_q <= 1'b0;
      ad_q <= 12'h000;
    end else if (hready) begin
      ap_q <= hsel && htrans[1];
      wr_q <= hwrite;
      ad_q <= haddr[11:0];
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= 32'h0;
      inten_q <= 32'h0;
      chout_q <= 32'h0;
    end else if (dp && wr_q) begin
      if (ad_q == TEFSW_CTRL_OFS) ctrl_q <= hwdata;
      if (ad_q == TEFSW_INTEN_OFS) inten_q <= hwdata;
      if (ad_q == TEFSW_CHOUT_OFS) chout_q <= hwdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  AST_UPD_FORCE: assert property (
    sw && hwdata[UPD_BIT] |=> cnt_ctl.psc_clear
      && cnt_ctl.cnt_reload == (ctrl_q[0] && !ctrl_q[1])
      && cnt_ctl.cnt_clear != cnt_ctl.cnt_reload)
    else $error("update force gives wrong counter control");
  AST_PSC_WITH_CNT: assert property (
    cnt_ctl.cnt_clear || cnt_ctl.cnt_reload |-> cnt_ctl.psc_clear)
    else $error("prescaler not cleared with counter");
  AST_NO_FORCE: assert property (
    sw && !hwdata[UPD_BIT] |=> !cnt_ctl.psc_clear)
    else $error("counter control pulse without update force");
  AST_ONE_PULSE: assert property (
    $rose(cnt_ctl.psc_clear) |=> !cnt_ctl.psc_clear)
    else $error("soft event pulse longer than one cycle");
  AST_BRK_POE: assert property (
    sw && hwdata[BRK_BIT] |-> ##2 !primary_output_enable)
    else $error("break force left output enable set");
  AST_FORCE_IRQ: assert property (
    sw && |(hwdata[7:0] & inten_q[7:0]) |-> ##2 irq)
    else $error("enabled soft event raised no interrupt");
  AST_UPD_IRQ: assert property (
    hw_evt.update && inten_q[UPD_BIT] |=> irq)
    else $error("update event raised no interrupt");
  AST_COMM_IRQ: assert property (
    hw_evt.commutation && inten_q[COMM_BIT] |=> irq)
    else $error("commutation event raised no interrupt");
  AST_TRIG_PAUSE: assert property (
    ctrl_q[CTRL_PAUSE_BIT] && inten_q[TRIG_BIT]
      && $changed(hw_evt.trig_level) |=> irq)
    else $error("trigger edge in pause mode missed");
  AST_COMM_SHADOW: assert property (
    sw && hwdata[COMM_BIT] && ctrl_q[CTRL_CSE_BIT]
      |-> ##2 chan_out_active == chout_q[19:0])
    else $error("commutation force did not load outputs");
  AST_SWEV_READ: assert property (
    dp && !wr_q && ad_q == TEFSW_SWEV_OFS |-> hrdata == 32'h0)
    else $error("soft event register read not zero");
endmodule

//--- verification/tb_top.sv
// Testbench of the timer event flags block over its register bus.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tefsw_pkg::*;
  logic                   hclk, hresetn, hsel, hwrite, hready, trg, r;
  logic                   hreadyout, hresp, poe, irq;
  logic [1:0]             htrans;
  logic [2:0]             hsize;
  logic [10:0]            ev;
  logic [31:0]            haddr, hwdata, hrdata, rd;
  logic [CNT_W-1:0]       cnt_value;
  tefsw_cnt_ctl_t         cnt_ctl;
  tefsw_chout_t [NCH-1:0] chan_out_active;
  int                     n_errors, n_tests, k;

  assign hready = hreadyout;
  tefsw_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .hw_evt({trg, ev}),
    .cnt_value(cnt_value), .cnt_ctl(cnt_ctl),
    .primary_output_enable(poe), .chan_out_active(chan_out_active),
    .irq(irq));

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  // Ready and read data are sampled mid-cycle, where they have settled.
  task automatic cyc();
    int t;
    t = 0;
    do begin
      @(negedge hclk);
      r = hready;
      rd = hrdata;
      t++;
      if (t > 40) begin
        n_errors++;
        finish_test();
      end
      @(posedge hclk);
    end while (r !== 1'b1);
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {20'h0, a};
    cyc();
    htrans <= 2'b00;
    hwdata <= d;
    cyc();
  endtask
  task automatic rchk(input string s, input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(s, e, rd);
  endtask
  task automatic pulse(input logic [10:0] v);
    @(posedge hclk);
    ev <= v;
    @(posedge hclk);
    ev <= 11'h0;
  endtask
  task automatic tset(input logic v);
    @(posedge hclk);
    trg <= v;
    repeat (2) @(posedge hclk);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {hresetn, hwrite, htrans, trg, ev, haddr, hwdata} = '0;
    hsel = 1'b1;
    hsize = 3'b010;
    cnt_value = 16'h1234;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rchk("swev", TEFSW_SWEV_OFS, 32'h0);
    rchk("unmapped", 12'hff0, 32'h0);
    chk("hresp", 32'h0, hresp);
    bus(1'b1, TEFSW_INTEN_OFS, 32'h1);
    pulse(11'h400);
    #1 chk("irq", 32'h1, irq);
    bus(1'b1, TEFSW_INTEN_OFS, 32'h0);
    #1 chk("irq masked", 32'h0, irq);
    bus(1'b1, TEFSW_FLAGS_OFS, 32'h1);
    bus(1'b1, TEFSW_INTEN_OFS, 32'hff);
    #1 chk("irq cleared", 32'h0, irq);
    pulse(11'h200);
    pulse(11'h100);
    for (k = 0; k < 4; k++) pulse(11'h001 << k);
    pulse(11'h010);
    rchk("hw flags", TEFSW_FLAGS_OFS, 32'hbe);
    bus(1'b1, TEFSW_FLAGS_OFS, 32'h1eff);
    for (k = 0; k < 2; k++) begin
      bus(1'b1, TEFSW_CTRL_OFS, k << CTRL_PAUSE_BIT);
      tset(1'b1);
      rchk("trig rise", TEFSW_FLAGS_OFS, 32'h40);
      bus(1'b1, TEFSW_FLAGS_OFS, 32'h40);
      tset(1'b0);
      rchk("trig fall", TEFSW_FLAGS_OFS, k << TRIG_BIT);
      bus(1'b1, TEFSW_FLAGS_OFS, 32'h40);
    end
    bus(1'b1, TEFSW_CTRL_OFS, 32'h20);
    for (k = 1; k < 8; k++) begin
      bus(1'b1, TEFSW_SWEV_OFS, 32'h1 << k);
      rchk("force", TEFSW_FLAGS_OFS, 32'h1 << k);
      #1 chk("force irq", 32'h1, irq);
      bus(1'b1, TEFSW_FLAGS_OFS, 32'hff);
    end
    chk("poe", 32'h0, poe);
    bus(1'b1, TEFSW_SWEV_OFS, 32'h0);
    rchk("zero force", TEFSW_FLAGS_OFS, 32'h0);
    for (k = 0; k < 4; k++) begin
      bus(1'b1, TEFSW_CTRL_OFS, k);
      bus(1'b1, TEFSW_SWEV_OFS, 32'h1);
      #1 chk("cnt ctl", (k == 1) ? 3'b011 : 3'b101, cnt_ctl);
    end
    bus(1'b1, TEFSW_FLAGS_OFS, 32'h1eff);
    bus(1'b1, TEFSW_CTRL_OFS, 32'h100);
    bus(1'b1, TEFSW_SWEV_OFS, 32'h2);
    rchk("capture", TEFSW_CAPV_OFS, 32'h1234);
    rchk("read clear", TEFSW_FLAGS_OFS, 32'h0);
    pulse(11'h010);
    pulse(11'h010);
    rchk("over hw", TEFSW_FLAGS_OFS, 32'h202);
    bus(1'b1, TEFSW_FLAGS_OFS, 32'h1eff);
    bus(1'b1, TEFSW_SWEV_OFS, 32'h2);
    bus(1'b1, TEFSW_SWEV_OFS, 32'h2);
    rchk("over force", TEFSW_FLAGS_OFS, 32'h202);
    bus(1'b1, TEFSW_CTRL_OFS, 32'h10);
    bus(1'b1, TEFSW_CHOUT_OFS, 32'ha5a5a);
    #1 chk("shadow hold", 32'h0, chan_out_active);
    bus(1'b1, TEFSW_SWEV_OFS, 32'h20);
    @(posedge hclk);
    #1 chk("commutation", 32'ha5a5a, chan_out_active);
    bus(1'b1, TEFSW_CTRL_OFS, 32'h0);
    bus(1'b1, TEFSW_CHOUT_OFS, 32'h12345);
    repeat (2) @(posedge hclk);
    #1 chk("no shadow", 32'h12345, chan_out_active);
    finish_test();
  end
endmodule

bind tefsw_top tefsw_assertions i_chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .hw_evt(hw_evt), .cnt_value(cnt_value),
  .cnt_ctl(cnt_ctl), .primary_output_enable(primary_output_enable),
  .chan_out_active(chan_out_active), .irq(irq));
